// ==== hw/bsnl_line_map.vh ====
// Purpose: constants for the per-line bit stuffing and NRZI line logic
// Assumes: one line serviced per gated bit service; registers one word wide
// Notes: state codes are the primary line state values of the scanner
// Summary of operation
// - turnaround delays end tag until zero shifted
// - empty field next service drops RTS, sets monitor
// - delete inserted zeros in data receive states
// - detect flags in receive and monitor states
// - seven ones in data receive is abort
// - insert zero after five ones unless disabled
// - count ones when counter nonzero and one seen
// - increment at seven wraps to zero, abort
// - transmit zero bit loads counter with one
// - plain receive zero loads counter with one
// - NRZI receive level change loads counter one
// - new zero-insert disable flag loads counter one
// - NRZI clear holds last line state one
// - NRZI transmit last state follows sent level
// - waiting for CTS sends mark, state one
// - CTS active: state one, data sent as plain level
// - NRZI receive last state follows received level
// - turnaround to monitor on CTS sets state one
// - software writes NRZI bit; NRZI transmit
// - NRZI transmit inverts send buffer on zero
// - NRZI clear means plain level coding
// - disable flag forces ones counter to one
`ifndef BSNL_LINE_MAP_VH
`define BSNL_LINE_MAP_VH
`define BSNL_LINES 16
`define BSNL_LW 4
`define BSNL_ST_MON_DSR 4'h4
`define BSNL_ST_MON_FLAG 4'h5
`define BSNL_ST_RX_DATA 4'h6
`define BSNL_ST_RX_ADDR 4'h7
`define BSNL_ST_TX_WAIT_CTS 4'h8
`define BSNL_ST_TX_DATA 4'h9
`define BSNL_ST_TX_A 4'hA
`define BSNL_ST_TX_TURN 4'hC
`define BSNL_ST_TX_D 4'hD
`define BSNL_FIELD_BITS 10
`define BSNL_ONES_RESET 3'h1
`define BSNL_CW_RESET 8'h09
`define BSNL_ONES_MAX 3'h7
`define BSNL_ONES_STUFF 3'h6
`define BSNL_ONES_FLAG 3'h7
`define BSNL_REG_STATE 4'h0
`define BSNL_REG_NRZI 4'h1
`define BSNL_REG_LLS 4'h2
`define BSNL_REG_LINE 4'h3
`define BSNL_REG_FIELD 4'h4
`define BSNL_REG_STATUS 4'h5
`define BSNL_REG_ZIDIS 4'h6
`define BSNL_CW_ONES_LSB 0
`define BSNL_CW_LLS 3
`define BSNL_CW_NRZI 4
`define BSNL_CW_ZID 5
`define BSNL_CW_TAGDLY 6
`define BSNL_CW_PEND 7
`define BSNL_CW_W 8
`endif

// ==== hw/bsnl_sync2.v ====
// Purpose: two flip-flop release of the asynchronous reset
// Assumes: reset_n active low
// Notes: assertion is immediate, release takes two edges
`timescale 1ns/1ps
module bsnl_sync2 (
  input wire clock,
  input wire reset_n,
  output reg rst_n_ff
);
  reg meta_ff;
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      meta_ff <= 1'b1;
      rst_n_ff <= meta_ff;
    end
  end
endmodule

// ==== hw/bsnl_line_logic.v ====
// Purpose: ones counter and last line state logic for a bit-oriented link
// Assumes: one line serviced per bit service pulse; inputs synchronous
// Notes: per-line state sits in a control word array, read-modify-write
`timescale 1ns/1ps
`include "bsnl_line_map.vh"
module bsnl_line_logic (
  // Clock and reset
  input wire clock,
  input wire reset_n,
  // Register port
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata_ff,
  // Bit service from the scanner
  input wire svc,
  input wire [3:0] svc_line,
  input wire [3:0] primary_line_state,
  input wire rx_bit,
  input wire tx_data_bit,
  input wire field_last_zero,
  input wire field_empty,
  input wire cts,
  input wire zero_insert_ctl,
  // Line interface side
  output reg line_tx_ff,
  output reg rts_ff,
  output reg xmt_mode_ff,
  output reg rx_data_ff,
  output reg rx_valid_ff,
  output reg stuff_ff,
  output reg flag_det_ff,
  output reg abort_det_ff,
  output reg tag_ff,
  output reg [3:0] new_state_ff,
  output reg state_wr_ff,
  output reg l2_pend_ff,
  output reg tx_shift_ff
);
  wire rst_n;
  bsnl_sync2 u_rst (
    .clock(clock),
    .reset_n(reset_n),
    .rst_n_ff(rst_n)
  );

  reg [`BSNL_CW_W-1:0] per_line_control_word [0:`BSNL_LINES-1];
  reg [3:0] line_sel_ff;
  reg [15:0] pend_ff;
  integer i;

  wire [`BSNL_CW_W-1:0] cw = per_line_control_word[svc_line];
  wire [2:0] ones = cw[`BSNL_CW_ONES_LSB+2:`BSNL_CW_ONES_LSB];
  wire lls = cw[`BSNL_CW_LLS];
  wire nrzi = cw[`BSNL_CW_NRZI];
  wire zid_old = cw[`BSNL_CW_ZID];
  wire tag_dly = cw[`BSNL_CW_TAGDLY];
  wire [3:0] st = primary_line_state;
  wire is_rx_data = (st == `BSNL_ST_RX_DATA) || (st == `BSNL_ST_RX_ADDR);
  wire is_rx_mon = is_rx_data || (st == `BSNL_ST_MON_DSR) || (st == `BSNL_ST_MON_FLAG);
  wire is_tx = (st == `BSNL_ST_TX_WAIT_CTS) || (st == `BSNL_ST_TX_DATA) ||
    (st == `BSNL_ST_TX_A) || (st == `BSNL_ST_TX_TURN) || (st == `BSNL_ST_TX_D);
  wire nrzi_tx_state = is_tx && (st != `BSNL_ST_TX_WAIT_CTS);

  reg [2:0] nxt_ones;
  reg nxt_lls;
  reg nxt_zid;
  reg nxt_tagdly;
  reg rx_one;
  reg tx_bit;
  reg send_level;
  reg do_stuff;
  reg nxt_flag;
  reg nxt_abort;
  reg nxt_tag;
  reg nxt_del;

  always @* begin
    nxt_ones = ones;
    nxt_lls = lls;
    nxt_zid = zid_old;
    nxt_tagdly = tag_dly;
    do_stuff = 1'b0;
    nxt_flag = 1'b0;
    nxt_abort = 1'b0;
    nxt_tag = 1'b0;
    nxt_del = 1'b0;
    tx_bit = tx_data_bit;
    send_level = line_tx_ff;
    // Receive data decoded by exclusive NOR with last line state
    rx_one = ~(rx_bit ^ lls);
    if (is_tx) begin
      nxt_zid = zero_insert_ctl;
      // Stuffed zero takes the bit slot after five ones
      if (!nxt_zid && ones == `BSNL_ONES_STUFF) begin
        do_stuff = 1'b1;
        tx_bit = 1'b0;
      end
      if (st == `BSNL_ST_TX_WAIT_CTS && !cts) begin
        send_level = 1'b1;
        nxt_lls = 1'b1;
      end else if (nrzi && nrzi_tx_state) begin
        send_level = tx_bit ? lls : ~lls;
        nxt_lls = send_level;
      end else begin
        send_level = tx_bit;
        nxt_lls = 1'b1;
      end
      if (nxt_zid) begin
        nxt_ones = `BSNL_ONES_RESET;
      end else if (!tx_bit) begin
        nxt_ones = `BSNL_ONES_RESET;
      end else if (ones != 3'h0) begin
        nxt_ones = (ones == `BSNL_ONES_MAX) ? 3'h0 : ones + 3'h1;
      end
      // Turnaround waits for zero into last field position, then empty
      if (st == `BSNL_ST_TX_TURN) begin
        if (tag_dly && field_empty) begin
          nxt_tag = 1'b1;
          nxt_tagdly = 1'b0;
        end else if (field_last_zero) begin
          nxt_tagdly = 1'b1;
        end
      end else begin
        nxt_tagdly = 1'b0;
      end
    end else if (is_rx_mon) begin
      nxt_tagdly = 1'b0;
      if (nrzi) begin
        if (rx_bit != lls) begin
          nxt_ones = `BSNL_ONES_RESET;
        end else if (ones != 3'h0) begin
          nxt_ones = (ones == `BSNL_ONES_MAX) ? 3'h0 : ones + 3'h1;
        end
        nxt_lls = rx_bit;
      end else begin
        if (!rx_bit) begin
          nxt_ones = `BSNL_ONES_RESET;
        end else if (ones != 3'h0) begin
          nxt_ones = (ones == `BSNL_ONES_MAX) ? 3'h0 : ones + 3'h1;
        end
        nxt_lls = 1'b1;
      end
      // Zero after six ones closes a flag
      if (!rx_one && ones == `BSNL_ONES_FLAG) begin
        nxt_flag = 1'b1;
      end
      if (is_rx_data) begin
        if (!rx_one && ones == `BSNL_ONES_STUFF) begin
          nxt_del = 1'b1;
        end
        if (rx_one && ones == `BSNL_ONES_MAX) begin
          nxt_abort = 1'b1;
        end
      end
    end
    if (!nrzi) begin
      nxt_lls = 1'b1;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < `BSNL_LINES; i = i + 1) begin
        per_line_control_word[i] <= `BSNL_CW_RESET;
      end
      pend_ff <= 16'h0000;
      line_sel_ff <= 4'h0;
      reg_rdata_ff <= 16'h0000;
      line_tx_ff <= 1'b1;
      rts_ff <= 1'b0;
      xmt_mode_ff <= 1'b0;
      rx_data_ff <= 1'b0;
      rx_valid_ff <= 1'b0;
      stuff_ff <= 1'b0;
      flag_det_ff <= 1'b0;
      abort_det_ff <= 1'b0;
      tag_ff <= 1'b0;
      new_state_ff <= 4'h0;
      state_wr_ff <= 1'b0;
      l2_pend_ff <= 1'b0;
      tx_shift_ff <= 1'b0;
    end else begin
      rx_valid_ff <= 1'b0;
      stuff_ff <= 1'b0;
      flag_det_ff <= 1'b0;
      abort_det_ff <= 1'b0;
      tag_ff <= 1'b0;
      state_wr_ff <= 1'b0;
      tx_shift_ff <= 1'b0;
      if (svc) begin
        per_line_control_word[svc_line] <=
          {pend_ff[svc_line] | nxt_tag, nxt_tagdly, nxt_zid, nrzi, nxt_lls, nxt_ones};
        if (is_tx) begin
          line_tx_ff <= send_level;
          tx_shift_ff <= ~do_stuff;
          stuff_ff <= do_stuff;
          rts_ff <= ~nxt_tag;
          xmt_mode_ff <= ~nxt_tag;
        end
        if (is_rx_mon) begin
          rx_data_ff <= rx_one;
          rx_valid_ff <= is_rx_data & ~nxt_del;
          flag_det_ff <= nxt_flag;
          abort_det_ff <= nxt_abort;
        end
        if (nxt_tag) begin
          tag_ff <= 1'b1;
          rts_ff <= 1'b0;
          xmt_mode_ff <= 1'b0;
          new_state_ff <= `BSNL_ST_MON_FLAG;
          state_wr_ff <= 1'b1;
          l2_pend_ff <= 1'b1;
        end else if (st == `BSNL_ST_TX_TURN && cts && !tag_dly && !field_last_zero
                     && field_empty) begin
          // CTS moves turnaround straight to monitor flag
          per_line_control_word[svc_line][`BSNL_CW_LLS] <= 1'b1;
          new_state_ff <= `BSNL_ST_MON_FLAG;
          state_wr_ff <= 1'b1;
        end
        if (nxt_tag) begin
          pend_ff[svc_line] <= 1'b1;
        end
      end
      if (reg_wr) begin
        if (reg_addr == `BSNL_REG_LINE) begin
          line_sel_ff <= reg_wdata[3:0];
        end else if (reg_addr == `BSNL_REG_NRZI && !(svc && svc_line == line_sel_ff)) begin
          per_line_control_word[line_sel_ff][`BSNL_CW_NRZI] <= reg_wdata[0];
        end else if (reg_addr == `BSNL_REG_LLS && !(svc && svc_line == line_sel_ff)) begin
          per_line_control_word[line_sel_ff][`BSNL_CW_LLS] <= reg_wdata[0];
        end else if (reg_addr == `BSNL_REG_STATUS) begin
          // Hardware set wins over clear in the same cycle
          if (reg_wdata[0] && !(svc && nxt_tag && svc_line == line_sel_ff)) begin
            pend_ff[line_sel_ff] <= 1'b0;
          end
        end
      end
      if (reg_wr && reg_addr == `BSNL_REG_STATUS) begin
        l2_pend_ff <= (svc && nxt_tag) | (|(pend_ff & ~({15'h0000, reg_wdata[0]} << line_sel_ff)));
      end else if (!(svc && nxt_tag)) begin
        l2_pend_ff <= |pend_ff;
      end
      if (reg_rd) begin
        if (reg_addr == `BSNL_REG_LINE) begin
          reg_rdata_ff <= {12'h000, line_sel_ff};
        end else if (reg_addr == `BSNL_REG_STATE) begin
          reg_rdata_ff <= {8'h00, per_line_control_word[line_sel_ff]};
        end else if (reg_addr == `BSNL_REG_NRZI) begin
          reg_rdata_ff <= {15'h0000, per_line_control_word[line_sel_ff][`BSNL_CW_NRZI]};
        end else if (reg_addr == `BSNL_REG_LLS) begin
          reg_rdata_ff <= {15'h0000, per_line_control_word[line_sel_ff][`BSNL_CW_LLS]};
        end else if (reg_addr == `BSNL_REG_STATUS) begin
          reg_rdata_ff <= pend_ff;
        end else begin
          reg_rdata_ff <= 16'h0000;
        end
      end else begin
        reg_rdata_ff <= 16'h0000;
      end
    end
  end
endmodule

// ==== test/bsnl_asserts.sv ====
// Purpose: port checks of the line logic
// Assumes: svc pulses one cycle
// Notes: bound to the top module in tb
`timescale 1ns/1ps
module bsnl_asserts (
  // Clock and reset
  input logic clock,
  input logic reset_n,
  // Service inputs
  input logic svc,
  input logic [3:0] primary_line_state,
  input logic cts,
  input logic zero_insert_ctl,
  input logic field_empty,
  // Watched outputs
  input logic line_tx_ff,
  input logic rts_ff,
  input logic xmt_mode_ff,
  input logic stuff_ff,
  input logic flag_det_ff,
  input logic abort_det_ff,
  input logic tag_ff,
  input logic [3:0] new_state_ff,
  input logic state_wr_ff,
  input logic l2_pend_ff,
  input logic tx_shift_ff
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  property p_tag_rts; tag_ff |-> !rts_ff && !xmt_mode_ff; endproperty
  a_tag_rts: assert property (p_tag_rts) else $error("tag left rts up");
  property p_tag_st; tag_ff |-> state_wr_ff && new_state_ff == 4'h5; endproperty
  a_tag_st: assert property (p_tag_st) else $error("tag state wrong");
  property p_tag_pend; tag_ff |-> l2_pend_ff; endproperty
  a_tag_pend: assert property (p_tag_pend) else $error("tag not pending");
  property p_tag_src; tag_ff |-> $past(svc && field_empty && primary_line_state == 4'hC);
  endproperty
  a_tag_src: assert property (p_tag_src) else $error("tag without cause");
  property p_mark; svc && primary_line_state == 4'h8 && !cts |=> line_tx_ff; endproperty
  a_mark: assert property (p_mark) else $error("no mark while waiting");
  property p_stuff; stuff_ff |-> $past(svc && !zero_insert_ctl) && !tx_shift_ff &&
    $past(primary_line_state) inside {4'h8, 4'h9, 4'hA, 4'hC, 4'hD}; endproperty
  a_stuff: assert property (p_stuff) else $error("stray stuffed zero");
  property p_flag; flag_det_ff |-> $past(svc) &&
    $past(primary_line_state) inside {4'h4, 4'h5, 4'h6, 4'h7}; endproperty
  a_flag: assert property (p_flag) else $error("stray flag");
  property p_abort; abort_det_ff |-> $past(svc) &&
    $past(primary_line_state) inside {4'h6, 4'h7}; endproperty
  a_abort: assert property (p_abort) else $error("stray abort");
  property p_idle; !$past(svc) |->
    !(stuff_ff || flag_det_ff || abort_det_ff || tag_ff || tx_shift_ff); endproperty
  a_idle: assert property (p_idle) else $error("pulse without service");
endmodule

// ==== test/bsnl_lib_model.sv ====
// Purpose: line interface base model
// Assumes: far station encodes the receive level
// Notes: clear to send trails request to send
`timescale 1ns/1ps
module bsnl_lib_model #(
  parameter int CTS_DLY = 4
) (
  // Clock
  input logic clock,
  // Modem controls
  input logic rts,
  output logic cts,
  // Receive line
  output logic rx_level
);
  logic [7:0] dly_ff = 8'h00;
  logic lvl_ff = 1'b1;
  assign cts = dly_ff[CTS_DLY-1];
  assign rx_level = lvl_ff;
  always @(posedge clock) begin
    dly_ff <= {dly_ff[6:0], rts};
  end
  // Far side NRZI: level flips on each zero
  task put(input logic b, input logic nz);
    lvl_ff <= nz ? (b ? lvl_ff : ~lvl_ff) : b;
  endtask
endmodule

// ==== test/tb.sv ====
// Purpose: self-checking bench of the line logic
// Assumes: one service every two cycles
// Notes: expected bits come from a counter model
`timescale 1ns/1ps
module tb;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] reg_addr = 4'h0, svc_line = 4'h0, pls = 4'h0, nst, lnv;
  logic [15:0] reg_wdata = 16'h0000, rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, svc = 1'b0, txd = 1'b0, fl0 = 1'b0, fe = 1'b0;
  logic zic = 1'b0, rx, cts, ltx, rts, xm, rxd, rxv, stf, flg, abt, tag, swr, l2p, shf;
  logic [31:0] seed = 32'd73, r;
  logic [2:0] tcnt, rcnt;
  logic tlev, rlev, mb;
  int n_fail = 0, cmp_count = 0, cyc = 0;
  bsnl_line_logic dut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(rdata),
    .svc(svc), .svc_line(svc_line), .primary_line_state(pls), .rx_bit(rx),
    .tx_data_bit(txd), .field_last_zero(fl0), .field_empty(fe), .cts(cts),
    .zero_insert_ctl(zic), .line_tx_ff(ltx), .rts_ff(rts), .xmt_mode_ff(xm),
    .rx_data_ff(rxd), .rx_valid_ff(rxv), .stuff_ff(stf), .flag_det_ff(flg),
    .abort_det_ff(abt), .tag_ff(tag), .new_state_ff(nst), .state_wr_ff(swr),
    .l2_pend_ff(l2p), .tx_shift_ff(shf));
  bsnl_lib_model lib (.clock(clock), .rts(rts), .cts(cts), .rx_level(rx));
  initial forever #2.5 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function logic [2:0] ones_nx(input logic [2:0] c, input logic b);
    return b ? (c == 3'h0 ? 3'h0 : c + 3'h1) : 3'h1;
  endfunction
  task print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk("rdata", rdata, e);
  endtask
  task sv(input logic [3:0] st, input logic d, nz, zi, input logic [1:0] f);
    @(posedge clock);
    svc <= 1'b1;
    svc_line <= lnv;
    pls <= st;
    txd <= d;
    zic <= zi;
    {fe, fl0} <= f;
    lib.put(d, nz);
    @(posedge clock);
    svc <= 1'b0;
    #1;
  endtask
  task tx(input logic d, nz, zi);
    logic s;
    s = tcnt == 3'h6 && !zi;
    tlev = nz ? (s || !d ? ~tlev : tlev) : d && !s;
    sv(tcnt[1] ? 4'hA : tcnt[0] ? 4'hD : 4'h9, d, 1'b0, zi, 2'b00);
    chk("stuff", stf, s);
    chk("shift", shf, !s);
    chk("line", ltx, tlev);
    tcnt = zi || s ? 3'h1 : ones_nx(tcnt, d);
  endtask
  task rxb(input logic d, nz);
    logic lv, db;
    lv = nz ? (d ? lib.lvl_ff : ~lib.lvl_ff) : d;
    db = nz ? lv == rlev : lv;
    rlev = lv;
    sv(4'h6 + nz, d, nz, 1'b0, 2'b00);
    chk("flag", flg, !db && rcnt == 3'h7);
    chk("abort", abt, db && rcnt == 3'h7);
    if (rcnt != 3'h0 && (rcnt < 3'h6 || (rcnt == 3'h6 && !db))) chk("valid", rxv, rcnt != 3'h6);
    if (rcnt != 3'h0 && rcnt < 3'h6) chk("rxdata", rxd, db);
    rcnt = ones_nx(rcnt, db);
  endtask
  initial begin
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    lnv = 4'h0;
    wr(4'h3, 16'h0000);
    sv(4'h8, 1'b0, 1'b0, 1'b0, 2'b00);
    chk("mark", ltx, 1'b1);
    rd(4'h0, 16'h0009);
    rd(4'h1, 16'h0000);
    rd(4'h7, 16'h0000);
    $display("test reset done");
    tcnt = 3'h1;
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      tx(i < 12 || r[1:0] != 2'b00, 1'b0, i >= 20 && i < 28);
    end
    lnv = 4'h1;
    wr(4'h3, 16'h0001);
    wr(4'h1, 16'h0001);
    wr(4'h2, 16'h0000);
    rd(4'h2, 16'h0000);
    rd(4'h1, 16'h0001);
    tcnt = 3'h1;
    tlev = 1'b0;
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      tx(i < 8 || r[1:0] != 2'b00, 1'b1, 1'b0);
    end
    rd(4'h2, {15'h0000, tlev});
    $display("test transmit done");
    for (int m = 0; m < 2; m++) begin
      lnv = 4'h2 + m;
      wr(4'h3, {12'h000, lnv});
      wr(4'h1, m);
      rcnt = 3'h1;
      rlev = 1'b1;
      for (int i = 0; i < 56; i++) begin
        r = rnd();
        rxb(i < 24 ? 24'b111110_1111110_1111111_0111 >> (23 - i) : r[2:0] != 3'h0, m);
      end
    end
    lnv = 4'h5;
    rcnt = 3'h1;
    for (int i = 0; i < 16; i++) begin
      mb = 16'h7EFF >> (15 - i);
      sv(4'h4 + i[0], mb, 1'b0, 1'b0, 2'b00);
      chk("mflag", flg, !mb && rcnt == 3'h7);
      chk("mabort", abt, 1'b0);
      chk("mvalid", rxv, 1'b0);
      chk("mdata", rxd, mb);
      rcnt = ones_nx(rcnt, mb);
    end
    $display("test receive done");
    lnv = 4'h4;
    wr(4'h3, 16'h0004);
    for (int k = 0; k < 4; k++) begin
      sv(4'hC, 1'b0, 1'b0, 1'b0, k == 1 ? 2'b10 : k == 2 ? 2'b01 : {k[1], k[1]});
      chk("tag", tag, k == 3);
      chk("turn", swr, k == 1 || k == 3);
    end
    chk("rts", {rts, xm}, 2'b00);
    chk("state", {swr, nst}, 5'h15);
    chk("pend", l2p, 1'b1);
    rd(4'h5, 16'h0010);
    wr(4'h5, 16'h0001);
    #1 chk("pclr", l2p, 1'b0);
    rd(4'h5, 16'h0000);
    $display("test tag done");
    print_verdict();
  end
endmodule
bind bsnl_line_logic bsnl_asserts chk_i (.clock(clock), .reset_n(reset_n), .svc(svc),
  .primary_line_state(primary_line_state), .cts(cts), .zero_insert_ctl(zero_insert_ctl),
  .field_empty(field_empty), .line_tx_ff(line_tx_ff), .rts_ff(rts_ff),
  .xmt_mode_ff(xmt_mode_ff), .stuff_ff(stuff_ff), .flag_det_ff(flag_det_ff),
  .abort_det_ff(abort_det_ff), .tag_ff(tag_ff), .new_state_ff(new_state_ff),
  .state_wr_ff(state_wr_ff), .l2_pend_ff(l2_pend_ff), .tx_shift_ff(tx_shift_ff));
